/* hw/irs_vresize.sv */
// Vertical resizer sequencer for one block of a divided frame
// Function
// - Scale every block by 256 over d
// - Write last output line phase after block
// - Record produced output line count per block
// - Write next destination line pointer per block
// - Shadowed settings apply at the frame start that begins an armed block
`timescale 1ns/1ps
module irs_vresize
    import irs_pkg::*;
#(
    parameter int LINE_W = 16
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic frame_start,
    input wire logic horizontal_sync,
    output logic out_line_strobe,
    output logic [31:0] out_line_addr,
    output logic [15:0] out_line_phase,
    output logic block_busy,
    output logic block_done
);
    // Parameter check at elaboration; line fields must fit the data word
    if (LINE_W < 2 || LINE_W > 32)
    begin : g_line_w_bad
        $error("LINE_W out of range");
    end

    // Software side copies, read back as stored; scale d is clamped to its limits
    logic [15:0] sw_d;
    logic [15:0] sw_phase;
    logic [LINE_W-1:0] sw_vstart;
    logic [LINE_W-1:0] sw_vheight;
    logic [LINE_W-1:0] sw_oheight;
    logic [31:0] sw_base;
    logic [31:0] sw_saddr;
    logic [31:0] sw_pitch;
    logic [LINE_W-1:0] sw_sline;
    logic sw_tmm;
    // Active copies taken at frame start
    logic [15:0] act_d;
    logic [LINE_W-1:0] act_vstart;
    logic [LINE_W-1:0] act_vheight;
    logic [LINE_W-1:0] act_oheight;
    logic [31:0] act_pitch;
    logic [LINE_W-1:0] act_sline;
    logic act_tmm;
    // Status registers
    logic [15:0] last_vphase_status;
    logic [LINE_W-1:0] output_line_count_status;
    logic [LINE_W-1:0] output_line_pointer_status;
    // Sequencer state and counters
    irs_state_type state;
    logic armed; // Start requested while busy, waits for idle
    logic [LINE_W-1:0] lines_in; // Input lines seen in block
    logic [LINE_W-1:0] out_cnt; // Output lines produced
    logic [31:0] next_addr; // Destination of next output line
    logic [15:0] last_phase; // Phase of last output line
    logic sof_take; // Frame start begins a block
    logic in_pair; // Line closes a pair inside the window
    logic stop_now; // Input line budget used up
    logic out_full; // Output line budget used up
    logic start_wr; // Start bit written
    logic [31:0] rd_mux;

    irs_phase_if ph ();

    irs_vphase u_vphase (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .ph(ph)
    );

    assign start_wr = reg_wr && reg_addr == IRS_REG_CTRL
                      && reg_wdata[IRS_CTRL_START_BIT];
    assign sof_take = state == IRS_ST_WAIT_SOF && frame_start;
    assign in_pair = horizontal_sync && lines_in > act_vstart;
    // terminal mode choice
    // Input count ends only after the closing pair is emitted
    assign stop_now = act_tmm && lines_in >= act_vheight;
    assign out_full = !act_tmm && out_cnt >= act_oheight;

    // Phase engine control
    // one step of d per output line
    assign ph.d = act_d;
    assign ph.init = sw_phase;
    assign ph.load = sof_take;
    assign ph.step = state == IRS_ST_EMIT && ph.below && !out_full;
    assign ph.wrap = state == IRS_ST_EMIT && !ph.below;

    // Register writes; start is a pulse and is not stored
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sw_d <= IRS_D_RESET;
            sw_phase <= IRS_PHASE_RESET;
            sw_vstart <= '0;
            sw_vheight <= '0;
            sw_oheight <= '0;
            sw_base <= '0;
            sw_saddr <= '0;
            sw_pitch <= '0;
            sw_sline <= '0;
            sw_tmm <= 1'b0;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                IRS_REG_CTRL: sw_tmm <= reg_wdata[IRS_CTRL_TMM_BIT];
                IRS_REG_SCALE_D:
                    sw_d <= reg_wdata[15:0] < IRS_D_MIN ? IRS_D_MIN :
                            reg_wdata[15:0] > IRS_D_MAX ? IRS_D_MAX :
                            reg_wdata[15:0];
                IRS_REG_INITIAL_VPHASE: sw_phase <= reg_wdata[15:0];
                IRS_REG_VERTICAL_INPUT_START:
                    sw_vstart <= reg_wdata[LINE_W-1:0];
                IRS_REG_VERTICAL_INPUT_HEIGHT:
                    sw_vheight <= reg_wdata[LINE_W-1:0];
                IRS_REG_VERTICAL_OUTPUT_HEIGHT:
                    sw_oheight <= reg_wdata[LINE_W-1:0];
                IRS_REG_DEST_BASE_ADDRESS: sw_base <= reg_wdata;
                IRS_REG_DEST_START_ADDRESS: sw_saddr <= reg_wdata;
                IRS_REG_DEST_LINE_PITCH: sw_pitch <= reg_wdata;
                IRS_REG_DEST_START_LINE: sw_sline <= reg_wdata[LINE_W-1:0];
                default: ;
            endcase
        end
    end

    // Shadow transfer at frame start of an armed block
    // settings latched only at frame start
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            act_d <= IRS_D_RESET;
            act_vstart <= '0;
            act_vheight <= '0;
            act_oheight <= '0;
            act_pitch <= '0;
            act_sline <= '0;
            act_tmm <= 1'b0;
        end
        else if (sof_take)
        begin
            act_d <= sw_d;
            act_vstart <= sw_vstart;
            act_vheight <= sw_vheight;
            act_oheight <= sw_oheight;
            act_pitch <= sw_pitch;
            act_sline <= sw_sline;
            act_tmm <= sw_tmm;
        end
    end

    // Block sequencer
    // one independent pass per block
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            state <= IRS_ST_IDLE;
        else
        begin
            case (state)
                IRS_ST_IDLE:
                    if (armed || start_wr)
                        state <= IRS_ST_WAIT_SOF;
                IRS_ST_WAIT_SOF:
                    if (frame_start)
                        state <= IRS_ST_RUN;
                IRS_ST_RUN:
                    if (in_pair)
                        state <= IRS_ST_EMIT;
                IRS_ST_EMIT:
                    if (out_full || (!ph.below && stop_now))
                        state <= IRS_ST_DONE;
                    else if (!ph.below)
                        state <= IRS_ST_RUN;
                IRS_ST_DONE:
                    state <= IRS_ST_IDLE;
                default:
                    state <= IRS_ST_IDLE;
            endcase
        end
    end

    // Start request kept while a block is still finishing
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            armed <= 1'b0;
        else if (start_wr && state != IRS_ST_IDLE)
            armed <= 1'b1;
        else if (state == IRS_ST_IDLE)
            armed <= 1'b0;
    end

    // Input line counter; syncs in EMIT are lost, hence the line budget
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            lines_in <= '0;
        else if (sof_take)
            lines_in <= '0;
        else if (state == IRS_ST_RUN && horizontal_sync)
            lines_in <= lines_in + 1'b1;
    end

    // Output line generation and destination walk
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            out_cnt <= '0;
            next_addr <= '0;
            last_phase <= IRS_PHASE_ONE;
            out_line_strobe <= 1'b0;
            out_line_addr <= '0;
            out_line_phase <= '0;
        end
        else
        begin
            out_line_strobe <= ph.step;
            if (sof_take)
            begin
                out_cnt <= '0;
                next_addr <= sw_saddr;
                last_phase <= IRS_PHASE_ONE;
            end
            else if (ph.step)
            begin
                out_cnt <= out_cnt + 1'b1;
                next_addr <= next_addr + act_pitch;
                last_phase <= ph.phase;
                out_line_addr <= next_addr;
                out_line_phase <= ph.phase;
            end
        end
    end

    // Status update at block end, held until the next block ends
    // written together
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            last_vphase_status <= IRS_PHASE_RESET;
            output_line_count_status <= '0;
            output_line_pointer_status <= '0;
        end
        else if (state == IRS_ST_DONE)
        begin
            last_vphase_status <= last_phase;
            output_line_count_status <= out_cnt;
            output_line_pointer_status <= act_sline + out_cnt;
        end
    end

    // Busy and done flags
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            block_busy <= 1'b0;
            block_done <= 1'b0;
        end
        else
        begin
            block_busy <= state != IRS_ST_IDLE || start_wr;
            block_done <= state == IRS_ST_DONE;
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb
    begin
        rd_mux = '0;
        case (reg_addr)
            IRS_REG_CTRL: rd_mux[IRS_CTRL_TMM_BIT] = sw_tmm;
            IRS_REG_SCALE_D: rd_mux[15:0] = sw_d;
            IRS_REG_INITIAL_VPHASE: rd_mux[15:0] = sw_phase;
            IRS_REG_VERTICAL_INPUT_START: rd_mux[LINE_W-1:0] = sw_vstart;
            IRS_REG_VERTICAL_INPUT_HEIGHT: rd_mux[LINE_W-1:0] = sw_vheight;
            IRS_REG_VERTICAL_OUTPUT_HEIGHT: rd_mux[LINE_W-1:0] = sw_oheight;
            IRS_REG_DEST_BASE_ADDRESS: rd_mux = sw_base;
            IRS_REG_DEST_START_ADDRESS: rd_mux = sw_saddr;
            IRS_REG_DEST_LINE_PITCH: rd_mux = sw_pitch;
            IRS_REG_DEST_START_LINE: rd_mux[LINE_W-1:0] = sw_sline;
            IRS_REG_LAST_VPHASE_STATUS: rd_mux[15:0] = last_vphase_status;
            IRS_REG_OUTPUT_LINE_COUNT_STATUS:
                rd_mux[LINE_W-1:0] = output_line_count_status;
            IRS_REG_OUTPUT_LINE_POINTER_STATUS:
                rd_mux[LINE_W-1:0] = output_line_pointer_status;
            IRS_REG_BUSY_STATUS: rd_mux[0] = block_busy;
            default: rd_mux = '0;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            reg_rdata <= '0;
        else
            reg_rdata <= reg_rd ? rd_mux : '0;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    emit_phase_a: assert property (out_line_strobe |->
        out_line_phase < IRS_PHASE_ONE)
        else $error("output line phase outside pair");
    phase_step_a: assert property (out_line_strobe |->
        ph.phase == out_line_phase + act_d)
        else $error("phase not advanced by d");
    last_phase_a: assert property (block_done |->
        last_vphase_status == last_phase)
        else $error("last phase status wrong");
    line_count_a: assert property (block_done |->
        output_line_count_status == out_cnt)
        else $error("line count status wrong");
    line_ptr_a: assert property (block_done |->
        output_line_pointer_status == act_sline + out_cnt)
        else $error("line pointer status wrong");
    status_hold_a: assert property (state != IRS_ST_DONE |=>
        $stable(output_line_count_status)
        && $stable(last_vphase_status))
        else $error("status changed between blocks");
    shadow_take_a: assert property (sof_take |=>
        act_d == $past(sw_d) && act_tmm == $past(sw_tmm))
        else $error("shadow not taken at frame start");
    shadow_keep_a: assert property (!sof_take |=>
        $stable(act_d))
        else $error("active setting changed mid frame");
    tmm_end_a: assert property (state == IRS_ST_DONE && act_tmm |->
        lines_in >= act_vheight)
        else $error("block ended before input line count");
    done_pulse_a: assert property (block_done |=>
        !block_done ##1 !out_line_strobe)
        else $error("done not a single pulse");

    block_done_c: cover property (block_done);
    emit_run_c: cover property (out_line_strobe ##1 out_line_strobe);
    upscale_c: cover property (sof_take ##1 act_d < IRS_PHASE_ONE);
    rearm_c: cover property (start_wr && state == IRS_ST_EMIT);
endmodule

/* hw/irs_pkg.sv */
// Package: register map, field positions and limits of the vertical resizer
package irs_pkg;
    // Register byte offsets
    localparam logic [7:0] IRS_REG_CTRL = 8'h00;
    localparam logic [7:0] IRS_REG_SCALE_D = 8'h04;
    localparam logic [7:0] IRS_REG_INITIAL_VPHASE = 8'h08;
    localparam logic [7:0] IRS_REG_VERTICAL_INPUT_START = 8'h0c;
    localparam logic [7:0] IRS_REG_VERTICAL_INPUT_HEIGHT = 8'h10;
    localparam logic [7:0] IRS_REG_VERTICAL_OUTPUT_HEIGHT = 8'h14;
    localparam logic [7:0] IRS_REG_DEST_BASE_ADDRESS = 8'h18;
    localparam logic [7:0] IRS_REG_DEST_START_ADDRESS = 8'h1c;
    localparam logic [7:0] IRS_REG_DEST_LINE_PITCH = 8'h20;
    localparam logic [7:0] IRS_REG_DEST_START_LINE = 8'h24;
    localparam logic [7:0] IRS_REG_LAST_VPHASE_STATUS = 8'h28;
    localparam logic [7:0] IRS_REG_OUTPUT_LINE_COUNT_STATUS = 8'h2c;
    localparam logic [7:0] IRS_REG_OUTPUT_LINE_POINTER_STATUS = 8'h30;
    localparam logic [7:0] IRS_REG_BUSY_STATUS = 8'h34;
    // Control register fields
    localparam int IRS_CTRL_START_BIT = 0;
    localparam int IRS_CTRL_TMM_BIT = 1;
    // Phase unit: one input line spacing
    localparam logic [15:0] IRS_PHASE_ONE = 16'h0100;
    // Ratio limits: 256/d between 1/16 and 8x
    localparam logic [15:0] IRS_D_MIN = 16'h0020;
    localparam logic [15:0] IRS_D_MAX = 16'h1000;
    // Reset values
    localparam logic [15:0] IRS_D_RESET = 16'h0100;
    localparam logic [15:0] IRS_PHASE_RESET = 16'h0000;
    // Sequencer states
    typedef enum logic [2:0] {
        IRS_ST_IDLE = 3'b000,
        IRS_ST_WAIT_SOF = 3'b001,
        IRS_ST_RUN = 3'b010,
        IRS_ST_EMIT = 3'b011,
        IRS_ST_DONE = 3'b100
    } irs_state_type;
endpackage

/* hw/irs_phase_if.sv */
// Interface: control and result of the vertical phase accumulator
`timescale 1ns/1ps
interface irs_phase_if;
    logic load; // Take initial phase
    logic [15:0] init; // Initial phase value
    logic step; // Advance by d after an output line
    logic wrap; // Move to next input line pair
    logic [15:0] d; // Vertical resize parameter
    logic [15:0] phase; // Current phase
    logic below; // Phase inside current line pair
    modport ctl (output load, init, step, wrap, d, input phase, below);
    modport eng (input load, init, step, wrap, d, output phase, below);
endinterface

/* hw/irs_vphase.sv */
// Vertical phase accumulator of the resizer
`timescale 1ns/1ps
module irs_vphase
    import irs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    irs_phase_if.eng ph
);
    // Phase register; load wins over step and wrap
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            ph.phase <= IRS_PHASE_RESET;
        else if (ph.load)
            ph.phase <= ph.init;
        else if (ph.step)
            ph.phase <= ph.phase + ph.d;
        else if (ph.wrap)
            ph.phase <= ph.phase - IRS_PHASE_ONE;
    end

    // Output lines are made only while phase is inside the pair
    assign ph.below = ph.phase < IRS_PHASE_ONE;
endmodule

/* tb/irs_src_model.sv */
// Upstream sensor controller model: frame start pulse and line syncs
`timescale 1ns/1ps
module irs_src_model
#(
    parameter int LINE_GAP = 16 // Idle clocks between two syncs
)
(
    input wire logic clk_sys,
    input wire logic go,
    input wire logic [15:0] n_lines,
    output logic frame_start,
    output logic horizontal_sync,
    output logic active
);
    // Pulse lines idle low between frames
    initial
    begin
        frame_start = 1'b0;
        horizontal_sync = 1'b0;
        active = 1'b0;
    end

    // One frame per go pulse; go is ignored while a frame runs
    always @(posedge clk_sys)
    begin
        if (go)
        begin
            active <= 1'b1;
            // Frame opens on its first, red, pixel
            frame_start <= 1'b1;
            @(posedge clk_sys);
            frame_start <= 1'b0;
            repeat (n_lines + 16'd11)
            begin
                repeat (LINE_GAP) @(posedge clk_sys);
                horizontal_sync <= 1'b1;
                @(posedge clk_sys);
                horizontal_sync <= 1'b0;
            end
            active <= 1'b0;
        end
    end
endmodule

/* tb/image_resizer_frame_division_h_tb.sv */
// Self-checking bench of the vertical resizer block sequencer
`timescale 1ns/1ps
module image_resizer_frame_division_h_tb
    import irs_pkg::*;
;
    localparam logic [31:0] PITCH = 32'h0000_0800; // Memory area width
    localparam logic [31:0] BASE = 32'h0001_0000; // Area start address
    localparam int H1 = 320; // Left output width, even and narrow
    localparam int OV = 1; // Filter margin lines
    localparam int B = 3; // Block height in lines
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic frame_start;
    logic horizontal_sync;
    logic out_line_strobe;
    logic [31:0] out_line_addr;
    logic [15:0] out_line_phase;
    logic block_busy;
    logic block_done;
    logic src_go = 1'b0;
    logic [15:0] src_lines = 16'h0;
    logic src_active;
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;
    int k = 0; // Output lines seen in current block
    logic [15:0] exp_ph[$]; // Expected phase of each output line
    int exp_last; // Expected last phase status
    logic [31:0] cur_sa; // Start address of current block

    irs_vresize irs_vresize_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_start(frame_start),
        .horizontal_sync(horizontal_sync), .out_line_strobe(out_line_strobe),
        .out_line_addr(out_line_addr), .out_line_phase(out_line_phase),
        .block_busy(block_busy), .block_done(block_done));
    irs_src_model irs_src_model_i (.clk_sys(clk_sys), .go(src_go),
        .n_lines(src_lines), .frame_start(frame_start),
        .horizontal_sync(horizontal_sync), .active(src_active));

    // 10 MHz system clock
    always #50 clk_sys = ~clk_sys;

    // Verdict and end of run, reached from the hang guard and the main sequence
    task automatic final_report;
        if (miscompares == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Hang guard, far above the few thousand cycles the run needs
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            $display("BAD %0t timeout", $time);
            final_report();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        check(v, exp);
    endtask

    function automatic logic sel(input int which);
        case (which)
            0: return block_busy;
            1: return frame_start;
            2: return block_done;
            default: return !src_active;
        endcase
    endfunction

    // Bounded wait for a handshake; a lapse counts as a fault
    task automatic wait_for(input int which, input int lim);
        int n;
        n = 0;
        // Let the current edge settle so a one-cycle pulse is not missed
        #1;
        while (sel(which) !== 1'b1 && n < lim)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= lim)
            check(32'h0, 32'h1);
    endtask

    // Reference phase walk: emit while below one line, then wrap
    task automatic walk(input int d, input int p, input int vst, input int hgt);
        exp_ph.delete();
        exp_last = 256;
        for (int i = vst + 1; i < hgt; i++)
        begin
            while (p < 256)
            begin
                exp_ph.push_back(16'(p));
                exp_last = p;
                p += d;
            end
            p -= 256;
        end
    endtask

    // Every produced line checked in the cycle it stands
    always @(posedge clk_sys)
    begin
        if (!sys_rst && out_line_strobe === 1'b1)
        begin
            check({16'h0, out_line_phase}, k < exp_ph.size() ? exp_ph[k] : 16'hffff);
            check(out_line_addr, cur_sa + PITCH * k);
            k++;
        end
    end

    // One block: program, arm, feed a frame, then read the status
    task automatic run_block(input int d, input int p0, input int vst,
        input int hgt, input logic [31:0] base, input logic [31:0] sl,
        input bit shadow, input int oh);
        walk(d, p0, vst, hgt);
        // Output count ending keeps only the first oh lines
        if (oh > 0)
        begin
            while (exp_ph.size() > oh)
                void'(exp_ph.pop_back());
            exp_last = exp_ph[exp_ph.size() - 1];
        end
        cur_sa = base + PITCH * sl;
        k = 0;
        wr(IRS_REG_SCALE_D, 32'(d));
        wr(IRS_REG_INITIAL_VPHASE, 32'(p0));
        wr(IRS_REG_VERTICAL_INPUT_START, 32'(vst));
        wr(IRS_REG_VERTICAL_INPUT_HEIGHT, 32'(hgt));
        wr(IRS_REG_VERTICAL_OUTPUT_HEIGHT, 32'(oh));
        wr(IRS_REG_DEST_BASE_ADDRESS, base);
        wr(IRS_REG_DEST_START_ADDRESS, cur_sa);
        wr(IRS_REG_DEST_LINE_PITCH, PITCH);
        wr(IRS_REG_DEST_START_LINE, sl);
        rdc(IRS_REG_DEST_BASE_ADDRESS, base);
        // Start; input line count ending unless oh is set
        wr(IRS_REG_CTRL, (oh > 0) ? 32'h1 : 32'h3);
        wait_for(0, 20);
        check({31'h0, block_busy}, 32'h1);
        @(posedge clk_sys);
        // Source frame is taller than the programmed input
        src_lines <= 16'(hgt);
        src_go <= 1'b1;
        @(posedge clk_sys);
        src_go <= 1'b0;
        if (shadow)
        begin
            // Change scale mid-block; the running block keeps the old one
            wait_for(1, 20);
            wr(IRS_REG_SCALE_D, 32'h40);
            rdc(IRS_REG_SCALE_D, 32'h40);
        end
        wait_for(2, 2000);
        check(32'(k), 32'(exp_ph.size()));
        rdc(IRS_REG_LAST_VPHASE_STATUS, 32'(exp_last));
        rdc(IRS_REG_OUTPUT_LINE_COUNT_STATUS, 32'(exp_ph.size()));
        rdc(IRS_REG_OUTPUT_LINE_POINTER_STATUS, sl + exp_ph.size());
        rdc(IRS_REG_BUSY_STATUS, 32'h0);
        wait_for(3, 1000);
    endtask

    // Main sequence: reset values, then two rows of split blocks
    initial
    begin
        int ds[3];
        int p;
        int p0;
        int hgt;
        logic [31:0] sl;
        logic [31:0] nsl;
        logic [31:0] plast;
        // Ratios 1x, 2x up, 1.5x down
        ds = '{256, 128, 384};
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rdc(IRS_REG_SCALE_D, {16'h0, IRS_D_RESET});
        rdc(IRS_REG_LAST_VPHASE_STATUS, 32'h0);
        rdc(IRS_REG_OUTPUT_LINE_POINTER_STATUS, 32'h0);
        rdc(8'h3c, 32'h0);
        foreach (ds[i])
        begin
            p = 256;
            sl = 32'h0;
            for (int row = 0; row < 2; row++)
            begin
                // Next initial phase from last one
                p0 = (p < 256) ? p + ds[i] - 256 : p - 256;
                hgt = (row == 0) ? B + 1 + OV : B + 1 + 2 * OV;
                run_block(ds[i], p0, OV, hgt, BASE, sl, 1'b0, 0);
                rd(IRS_REG_OUTPUT_LINE_POINTER_STATUS, nsl);
                rd(IRS_REG_LAST_VPHASE_STATUS, plast);
                run_block(ds[i], p0, OV, hgt, BASE + 2 * H1, sl,
                    i == 2 && row == 1, 0);
                sl = nsl;
                p = int'(plast);
            end
        end
        // Output line count ending, the other terminal mode
        run_block(128, 0, OV, B + 1 + 2 * OV, BASE, sl, 1'b0, 3);
        // Status stays put and ignores writes until the next block
        wr(IRS_REG_OUTPUT_LINE_COUNT_STATUS, 32'hffff);
        repeat (20) @(posedge clk_sys);
        rdc(IRS_REG_OUTPUT_LINE_COUNT_STATUS, 32'(exp_ph.size()));
        final_report();
    end
endmodule
